// ===== verilog/zol_regs.svh
/*
  Offsets, field positions, reset values and encodings of the zero-overhead
  loop unit. Included by the loop unit only; definitions, no logic.
*/
`ifndef ZOL_REGS_SVH
`define ZOL_REGS_SVH

`define AUX_ADDR_W       12
`define LOOP_BEGIN_IDX   12'h002
`define LOOP_LAST_IDX    12'h003
`define LOOP_BEGIN_RST   32'h0000_0000
`define LOOP_LAST_RST    32'h0000_0000
`define MAJOR_HI         31
`define MAJOR_LO         27
`define MAJOR_LOOP       5'h04
`define SUBOP_HI         21
`define SUBOP_LO         16
`define SUBOP_LOOP       6'h28
`define MODE_HI          23
`define MODE_LO          22
`define MODE_UNCOND      2'h2
`define MODE_COND        2'h3
`define COND_SEL_BIT     5
`define DISP_LO_HI       11
`define DISP_LO_LO       6
`define DISP_HI_HI       5
`define DISP_HI_LO       0
`define CC_HI            4
`define CC_LO            0
`define COUNT_LAST       32'h0000_0001

`endif

// ===== verilog/zol_pkg.sv
/*
  Types shared by the zero-overhead loop unit and its surroundings.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package zol_pkg;
  typedef logic [31:0] addr_t;
  typedef enum logic [4:0] {
    CC_AL  = 5'h00, CC_EQ  = 5'h01, CC_NE = 5'h02, CC_PL = 5'h03,
    CC_MI  = 5'h04, CC_CS  = 5'h05, CC_CC = 5'h06, CC_VS = 5'h07,
    CC_VC  = 5'h08, CC_GT  = 5'h09, CC_GE = 5'h0a, CC_LT = 5'h0b,
    CC_LE  = 5'h0c, CC_HI  = 5'h0d, CC_LS = 5'h0e, CC_PNZ = 5'h0f
  } cond_t;
endpackage

// ===== verilog/zero_overhead_loop_unit.sv
/*
  Zero-overhead loop unit: executes the loop-setup instructions, holds the
  loop begin / loop end auxiliary registers and the iteration counter, and
  requests a program-counter reload when the fetch reaches the loop end.
  Assumes the fetch, execute and auxiliary-register logic of the core run
  on the same clock, so no input is synchronised.
*/
`timescale 1ns/1ps
`include "zol_regs.svh"

// Functional notes
// [RULE_01] Condition false: branch to aligned base plus displacement
// [RULE_02] Condition true: load loop end and begin
// [RULE_03] Unconditional form always loads both registers
// [RULE_04] Base is instruction address forced word aligned
// [RULE_05] Condition codes 00000 to 00111 decoded
// [RULE_06] Condition codes 01000 to 01111 decoded
// [RULE_07] Conditional form: unsigned 6-bit forward offset
// [RULE_08] Unconditional form: signed 12-bit offset
// [RULE_09] Reserved encoding bits are ignored
// [RULE_10] Software avoids discouraged operand mode encodings
// [RULE_11] Loop-end detection always active, no enable
// [RULE_12] Reset clears loop end register to zero
// [RULE_13] Software keeps setup out of delay slots
// [RULE_14] End match, count not one: reload, decrement
// [RULE_15] End match, count one: advance, decrement
// [RULE_16] Software writes only instruction start addresses
// [RULE_17] Counter may be undefined after early exit
// [RULE_18] Nesting needs save/restore; no setup near end
// [RULE_19] Software never loads the counter from memory
// [RULE_20] Plain branches allowed anywhere inside the body
// [RULE_21] Three fetches between register write and end
// [RULE_22] Loop body holds at least two words
// [RULE_23] Displacement scaled by two before adding
module zero_overhead_loop_unit (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   clk_en,
  input  wire logic                   instr_valid,
  input  wire logic [31:0]            instr_word,
  input  wire zol_pkg::addr_t         current_instr_address,
  input  wire zol_pkg::addr_t         next_seq_address,
  input  wire logic                   flag_z,
  input  wire logic                   flag_n,
  input  wire logic                   flag_c,
  input  wire logic                   flag_v,
  input  wire logic                   fetch_valid,
  input  wire zol_pkg::addr_t         next_fetch_address,
  input  wire logic                   aux_wr_en,
  input  wire logic                   aux_rd_en,
  input  wire logic [`AUX_ADDR_W-1:0] aux_addr,
  input  wire logic [31:0]            aux_wr_data,
  input  wire logic                   count_wr_en,
  input  wire logic [31:0]            count_wr_data,
  output logic [31:0]                 aux_rd_data_r,
  output logic                        aux_rd_hit_r,
  output zol_pkg::addr_t              loop_begin_address_r,
  output zol_pkg::addr_t              loop_last_address_r,
  output logic [31:0]                 iteration_counter_r,
  output logic                        pc_load_r,
  output zol_pkg::addr_t              pc_load_addr_r
);
  import zol_pkg::*;

  // ------------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------------
  logic        is_loop_op;
  logic        op_uncond;
  logic        op_cond;
  logic        op_setup;
  logic [11:0] disp_s12;
  logic [5:0]  disp_u6;
  addr_t       disp;
  addr_t       aligned_current_address;
  addr_t       setup_target;
  logic        cc_ok;
  logic        setup_true;
  logic        setup_false;
  logic        end_hit;
  logic        count_is_last;

  // Only opcode, sub-opcode, mode and, in the conditional form, bit 5 are examined; reserved bits are not
  assign is_loop_op = instr_valid
    && instr_word[`MAJOR_HI:`MAJOR_LO] == `MAJOR_LOOP
    && instr_word[`SUBOP_HI:`SUBOP_LO] == `SUBOP_LOOP;  // RULE_09
  assign op_uncond = is_loop_op
    && instr_word[`MODE_HI:`MODE_LO] == `MODE_UNCOND;
  // Discouraged mode encodings are treated as no operation
  assign op_cond = is_loop_op
    && instr_word[`MODE_HI:`MODE_LO] == `MODE_COND
    && instr_word[`COND_SEL_BIT];  // RULE_10
  assign op_setup = op_uncond || op_cond;

  assign disp_u6  = instr_word[`DISP_LO_HI:`DISP_LO_LO];  // RULE_07
  assign disp_s12 = {instr_word[`DISP_HI_HI:`DISP_HI_LO],
                     instr_word[`DISP_LO_HI:`DISP_LO_LO]};  // RULE_08

  // Halfword units: u6 reaches +126, s12 reaches -4096..+4094 bytes
  always_comb begin
    if (op_uncond) begin
      disp = {{19{disp_s12[11]}}, disp_s12, 1'b0};  // RULE_23
    end else begin
      disp = {25'h0, disp_u6, 1'b0};  // RULE_23
    end
  end

  assign aligned_current_address = {current_instr_address[31:2], 2'b00};  // RULE_04
  assign setup_target = aligned_current_address + disp;  // RULE_01

  // ------------------------------------------------------------------
  // Condition evaluation
  // ------------------------------------------------------------------
  always_comb begin
    unique case (cond_t'(instr_word[`CC_HI:`CC_LO]))
      CC_AL:   cc_ok = 1'b1;  // RULE_05
      CC_EQ:   cc_ok = flag_z;
      CC_NE:   cc_ok = !flag_z;
      CC_PL:   cc_ok = !flag_n;
      CC_MI:   cc_ok = flag_n;
      CC_CS:   cc_ok = flag_c;
      CC_CC:   cc_ok = !flag_c;
      CC_VS:   cc_ok = flag_v;
      CC_VC:   cc_ok = !flag_v;  // RULE_06
      CC_GT:   cc_ok = (flag_n == flag_v) && !flag_z;
      CC_GE:   cc_ok = (flag_n == flag_v);
      CC_LT:   cc_ok = (flag_n != flag_v);
      CC_LE:   cc_ok = flag_z || (flag_n != flag_v);
      CC_HI:   cc_ok = !flag_c && !flag_z;
      CC_LS:   cc_ok = flag_c || flag_z;
      CC_PNZ:  cc_ok = !flag_n && !flag_z;
      // Extension codes above 01111 are not provided: never true
      default: cc_ok = 1'b0;
    endcase
  end

  assign setup_true  = op_uncond || (op_cond && cc_ok);  // RULE_03
  assign setup_false = op_cond && !cc_ok;

  // ------------------------------------------------------------------
  // Loop-end detection
  // ------------------------------------------------------------------
  // No enable bit: a reset value of zero makes address zero a trap
  assign end_hit = fetch_valid
    && next_fetch_address == loop_last_address_r;  // RULE_11
  assign count_is_last = iteration_counter_r == `COUNT_LAST;

  // ------------------------------------------------------------------
  // Loop registers
  // ------------------------------------------------------------------
  // The setup instruction wins over a register write in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      loop_last_address_r <= `LOOP_LAST_RST;  // RULE_12
    end else if (clk_en) begin
      if (setup_true) begin
        loop_last_address_r <= setup_target;  // RULE_02
      end else if (aux_wr_en && aux_addr == `LOOP_LAST_IDX) begin
        loop_last_address_r <= aux_wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      loop_begin_address_r <= `LOOP_BEGIN_RST;
    end else if (clk_en) begin
      if (setup_true) begin
        loop_begin_address_r <= next_seq_address;  // RULE_02
      end else if (aux_wr_en && aux_addr == `LOOP_BEGIN_IDX) begin
        loop_begin_address_r <= aux_wr_data;
      end
    end
  end

  // A core-register write beats the decrement; an early exit through a
  // branch at the end leaves the count as the hardware happened to leave it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      iteration_counter_r <= 32'h0;
    end else if (clk_en) begin
      if (count_wr_en) begin
        iteration_counter_r <= count_wr_data;
      end else if (end_hit) begin
        iteration_counter_r <= iteration_counter_r - 32'h1;  // RULE_14 RULE_15 RULE_17
      end
    end
  end

  // ------------------------------------------------------------------
  // Program-counter redirect
  // ------------------------------------------------------------------
  // A failed conditional setup is a taken branch and so outranks loop-back
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pc_load_r      <= 1'b0;
      pc_load_addr_r <= 32'h0;
    end else if (clk_en) begin
      if (setup_false) begin
        pc_load_r      <= 1'b1;  // RULE_01
        pc_load_addr_r <= {setup_target[31:1], 1'b0};
      end else if (end_hit && !count_is_last) begin
        pc_load_r      <= 1'b1;  // RULE_14 RULE_20
        pc_load_addr_r <= loop_begin_address_r;
      end else begin
        pc_load_r      <= 1'b0;  // RULE_15
      end
    end
  end

  // ------------------------------------------------------------------
  // Auxiliary register read
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      aux_rd_data_r <= 32'h0;
      aux_rd_hit_r  <= 1'b0;
    end else if (clk_en) begin
      aux_rd_hit_r <= 1'b0;
      aux_rd_data_r <= 32'h0;
      if (aux_rd_en && aux_addr == `LOOP_BEGIN_IDX) begin
        aux_rd_data_r <= loop_begin_address_r;
        aux_rd_hit_r  <= 1'b1;
      end else if (aux_rd_en && aux_addr == `LOOP_LAST_IDX) begin
        aux_rd_data_r <= loop_last_address_r;
        aux_rd_hit_r  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_false_branch: assert property (@(posedge clk) disable iff (!resetn)  // RULE_01
    clk_en && setup_false |=> pc_load_r
      && pc_load_addr_r == {$past(setup_target[31:1]), 1'b0})
    else $error("failed conditional setup did not branch");

  a_true_end: assert property (@(posedge clk) disable iff (!resetn)  // RULE_02
    clk_en && op_cond && cc_ok |=> loop_last_address_r == $past(setup_target)
      && loop_begin_address_r == $past(next_seq_address) && !pc_load_r)
    else $error("true conditional setup did not load registers");

  a_uncond_load: assert property (@(posedge clk) disable iff (!resetn)  // RULE_03
    clk_en && op_uncond |=> loop_last_address_r
      == $past({current_instr_address[31:2], 2'b00}) + $past(disp))
    else $error("unconditional setup did not load loop end");

  a_base_align: assert property (@(posedge clk) disable iff (!resetn)  // RULE_04
    clk_en && op_cond && instr_word[11:6] == 6'h0 && cc_ok
      |=> loop_last_address_r[1:0] == 2'b00)
    else $error("base address not word aligned");

  a_cc_always: assert property (@(posedge clk) disable iff (!resetn)  // RULE_05
    clk_en && op_cond && instr_word[4:0] == 5'h00 |=> !pc_load_r)
    else $error("always condition branched");

  a_cc_gt: assert property (@(posedge clk) disable iff (!resetn)  // RULE_06
    op_cond && instr_word[4:0] == 5'h09 |-> cc_ok == (!flag_z && flag_n == flag_v))
    else $error("signed greater decoded wrongly");

  a_disp_range: assert property (@(posedge clk) disable iff (!resetn)  // RULE_08
    op_uncond |-> (disp == {{19{instr_word[5]}}, instr_word[5:0], instr_word[11:6], 1'b0}))
    else $error("signed displacement scaled wrongly");

  a_loop_back: assert property (@(posedge clk) disable iff (!resetn)  // RULE_14
    clk_en && end_hit && !count_is_last && !setup_false && !count_wr_en
      |=> pc_load_r && pc_load_addr_r == $past(loop_begin_address_r)
        && iteration_counter_r == $past(iteration_counter_r) - 32'h1)
    else $error("loop-back or decrement missing");

  a_last_pass: assert property (@(posedge clk) disable iff (!resetn)  // RULE_15
    clk_en && end_hit && count_is_last && !setup_false && !count_wr_en
      |=> !pc_load_r && iteration_counter_r == 32'h0)
    else $error("final iteration did not fall through");

  a_reset_end: assert property (@(posedge clk)  // RULE_12
    !resetn |=> loop_last_address_r == 32'h0)
    else $error("loop end not cleared by reset");

  // ------------------------------------------------------------------
  // Assertions: decode, reach, detection and freeze
  // ------------------------------------------------------------------
  // Codes are checked singly so that a swapped table entry is named

  a_uncond_begin: assert property (@(posedge clk) disable iff (!resetn)  // RULE_03
    clk_en && op_uncond |=> loop_begin_address_r == $past(next_seq_address))
    else $error("unconditional setup did not load loop begin");

  a_base_low: assert property (@(posedge clk) disable iff (!resetn)  // RULE_04
    clk_en && setup_true |=> loop_last_address_r[1:0] == $past(disp[1:0]))
    else $error("loop end carries base address low bits");

  a_cc_eq: assert property (@(posedge clk) disable iff (!resetn)  // RULE_05
    op_cond && instr_word[4:0] == 5'h01 |-> cc_ok == flag_z)
    else $error("zero condition decoded wrongly");

  a_cc_carry: assert property (@(posedge clk) disable iff (!resetn)  // RULE_05
    op_cond && instr_word[4:0] == 5'h06 |-> cc_ok == !flag_c)
    else $error("carry clear condition decoded wrongly");

  a_cc_ls: assert property (@(posedge clk) disable iff (!resetn)  // RULE_06
    op_cond && instr_word[4:0] == 5'h0e |-> cc_ok == (flag_c || flag_z))
    else $error("lower or same condition decoded wrongly");

  // Extension codes are absent, so a setup naming one always branches
  a_cc_ext: assert property (@(posedge clk) disable iff (!resetn)  // RULE_01
    op_cond && instr_word[4] |-> !cc_ok)
    else $error("extension condition code evaluated true");

  a_cond_reach: assert property (@(posedge clk) disable iff (!resetn)  // RULE_07 RULE_23
    op_cond |-> disp == {25'h0, instr_word[11:6], 1'b0} && disp <= 32'h0000_007e)
    else $error("conditional displacement out of reach");

  a_reserved_skip: assert property (@(posedge clk) disable iff (!resetn)  // RULE_09
    instr_valid && instr_word[31:27] == 5'h04 && instr_word[21:16] == 6'h28
      && instr_word[23:22] == 2'h2 |-> op_setup)
    else $error("reserved bits blocked an unconditional setup");

  a_mode_refused: assert property (@(posedge clk) disable iff (!resetn)  // RULE_10
    !instr_word[23] || (instr_word[22] && !instr_word[5]) |-> !op_setup)
    else $error("discouraged mode encoding executed");

  a_end_detect: assert property (@(posedge clk) disable iff (!resetn)  // RULE_11
    clk_en && fetch_valid && next_fetch_address == loop_last_address_r && !count_wr_en
      |=> iteration_counter_r == $past(iteration_counter_r) - 32'h1)
    else $error("loop end match did not decrement counter");

  a_count_load: assert property (@(posedge clk) disable iff (!resetn)  // RULE_19
    clk_en && count_wr_en |=> iteration_counter_r == $past(count_wr_data))
    else $error("counter write lost");

  a_read_end: assert property (@(posedge clk) disable iff (!resetn)  // RULE_02
    clk_en && aux_rd_en && aux_addr == `LOOP_LAST_IDX
      |=> aux_rd_hit_r && aux_rd_data_r == $past(loop_last_address_r))
    else $error("loop end read returned wrong data");

  // Freeze check covers both loop registers and the counter, the redirect pulse included
  a_freeze_hold: assert property (@(posedge clk) disable iff (!resetn)  // RULE_11
    !clk_en |=> $stable(loop_last_address_r) && $stable(loop_begin_address_r)
      && $stable(iteration_counter_r) && $stable(pc_load_r))
    else $error("state changed while the clock enable was low");

  a_false_pulse: assert property (@(posedge clk) disable iff (!resetn)  // RULE_01
    clk_en && setup_false ##1 clk_en && !setup_false && !end_hit |=> !pc_load_r)
    else $error("branch request stood longer than one cycle");
endmodule // zero_overhead_loop_unit

// ===== sim/fetch_model.sv
/*
  Fetch-side model: steps word addresses from a start point and follows
  the unit's redirect pulse. Assumes one clock shared with the unit.
*/
`timescale 1ns/1ps
module fetch_model (
  input  wire logic           clk,
  input  wire logic           run,
  input  wire zol_pkg::addr_t start_addr,
  input  wire logic           pc_load_r,
  input  wire zol_pkg::addr_t pc_load_addr_r,
  output logic                fetch_valid,
  output zol_pkg::addr_t      next_fetch_address
);
  import zol_pkg::*;
  initial begin
    fetch_valid = 1'b0;
    next_fetch_address = 32'h0000_0000;
  end
  // Idle address toggles each cycle so a stale value is never trusted
  always @(posedge clk) begin
    fetch_valid <= run;
    if (!run)
      next_fetch_address <= ~next_fetch_address;
    else if (pc_load_r)
      next_fetch_address <= pc_load_addr_r;
    else if (!fetch_valid)
      next_fetch_address <= start_addr;
    else
      next_fetch_address <= next_fetch_address + 32'h0000_0004;
  end
endmodule // fetch_model

// ===== sim/zero_overhead_loop_unit_tb.sv
/*
  Self-checking bench of the loop unit: expectations go to queues, a
  monitor compares redirects and reads. Assumes zol_pkg, fetch_model.
*/
`timescale 1ns/1ps
module zero_overhead_loop_unit_tb;
  import zol_pkg::*;
  logic        clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, instr_valid = 1'b0;
  logic        flag_z = 1'b0, flag_n = 1'b0, flag_c = 1'b0, flag_v = 1'b0, run = 1'b0;
  logic        aux_wr_en = 1'b0, aux_rd_en = 1'b0, count_wr_en = 1'b0, rd_was = 1'b0;
  logic [31:0] instr_word = 32'h0, count_wr_data = 32'h0, aux_wr_data = 32'h0;
  logic [11:0] aux_addr = 12'h0, d;
  addr_t       current_instr_address = 32'h0, next_seq_address = 32'h0, start_addr = 32'h100;
  addr_t       next_fetch_address, loop_begin_address_r, loop_last_address_r;
  addr_t       pc_load_addr_r, lb, ll, a, t;
  logic [31:0] aux_rd_data_r, iteration_counter_r;
  logic        aux_rd_hit_r, pc_load_r, fetch_valid;
  int          mismatches = 0, samples_checked = 0, n;
  addr_t       exp_pc[$];
  logic [32:0] exp_rd[$];

  always #2 clk = ~clk;

  zero_overhead_loop_unit u_zero_overhead_loop_unit (.clk, .resetn, .clk_en, .instr_valid,
    .instr_word, .current_instr_address, .next_seq_address, .flag_z, .flag_n, .flag_c,
    .flag_v, .fetch_valid, .next_fetch_address, .aux_wr_en, .aux_rd_en, .aux_addr,
    .aux_wr_data, .count_wr_en, .count_wr_data, .aux_rd_data_r, .aux_rd_hit_r,
    .loop_begin_address_r, .loop_last_address_r, .iteration_counter_r, .pc_load_r,
    .pc_load_addr_r);
  fetch_model u_fetch_model (.clk, .run, .start_addr, .pc_load_r, .pc_load_addr_r,
    .fetch_valid, .next_fetch_address);

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_rd(input logic [32:0] g, input logic [32:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic ev(input logic [4:0] cc);
    case (cc)
      5'h00: return 1'b1;
      5'h01: return flag_z;
      5'h02: return !flag_z;
      5'h03: return !flag_n;
      5'h04: return flag_n;
      5'h05: return flag_c;
      5'h06: return !flag_c;
      5'h07: return flag_v;
      5'h08: return !flag_v;
      5'h09: return (flag_n == flag_v) && !flag_z;
      5'h0a: return flag_n == flag_v;
      5'h0b: return flag_n != flag_v;
      5'h0c: return flag_z || (flag_n != flag_v);
      5'h0d: return !flag_c && !flag_z;
      5'h0e: return flag_c || flag_z;
      5'h0f: return !flag_n && !flag_z;
      default: return 1'b0;
    endcase
  endfunction
  task automatic ex(input logic [1:0] m, input logic [5:0] lo, input logic [5:0] d6,
                    input addr_t ad);
    logic [31:0] w;
    w = $urandom;
    w[31:27] = 5'h04;
    w[23:22] = m;
    w[21:16] = 6'h28;
    w[11:0] = {d6, lo};
    @(negedge clk);
    instr_word = w;
    instr_valid = 1'b1;
    current_instr_address = ad;
    next_seq_address = ad + 32'h4;
    @(negedge clk);
    instr_valid = 1'b0;
  endtask
  task automatic rd(input logic [11:0] ad, input logic [32:0] e);
    exp_rd.push_back(e);
    @(negedge clk);
    aux_rd_en = 1'b1;
    aux_addr = ad;
    @(negedge clk);
    aux_rd_en = 1'b0;
  endtask
  task automatic wr(input logic cnt, input logic [11:0] ad, input logic [31:0] v);
    @(negedge clk);
    count_wr_en = cnt;
    aux_wr_en = !cnt;
    aux_addr = ad;
    aux_wr_data = v;
    count_wr_data = v;
    @(negedge clk);
    count_wr_en = 1'b0;
    aux_wr_en = 1'b0;
  endtask
  task automatic regs;
    rd(12'h003, {1'b1, ll});
    rd(12'h002, {1'b1, lb});
    chk_val(loop_last_address_r, ll);
    chk_val(loop_begin_address_r, lb);
  endtask

  // ----
  // Monitor: redirects and read data are matched to the oldest note
  // ----
  always @(posedge clk) begin
    rd_was = aux_rd_en;
    #1;
    if (pc_load_r === 1'b1)
      chk_val(pc_load_addr_r, exp_pc.size() ? exp_pc.pop_front() : 32'hx);
    if (rd_was === 1'b1)
      chk_rd({aux_rd_hit_r, aux_rd_data_r}, exp_rd.pop_front());
  end

  initial begin
    void'($urandom(95939));
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    lb = 32'h0;
    ll = 32'h0;
    regs();
    rd(12'h004, 33'h0);
    chk_val(iteration_counter_r, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 64; i++) begin
      {flag_z, flag_n, flag_c, flag_v} = 4'($urandom);
      a = $urandom & ~32'h1;
      d = 12'($urandom);
      t = {a[31:2], 2'b00} + {25'h0, d[5:0], 1'b0};
      if (ev(i[4:0])) begin
        ll = t;
        lb = a + 32'h4;
      end
      else
        exp_pc.push_back(t);
      ex(2'h3, {1'b1, i[4:0]}, d[5:0], a);
      regs();
    end
    $display("test conditional done");
    for (int i = 0; i < 8; i++) begin
      a = $urandom & ~32'h1;
      d = (i == 0) ? 12'h800 : (i == 1) ? 12'h7ff : 12'($urandom);
      ll = {a[31:2], 2'b00} + {{19{d[11]}}, d, 1'b0};
      lb = a + 32'h4;
      ex(2'h2, d[11:6], d[5:0], a);
      regs();
    end
    $display("test unconditional done");
    clk_en = 1'b0;
    ex(2'h2, 6'h01, 6'h02, 32'h80);
    clk_en = 1'b1;
    regs();
    $display("test freeze done");
    for (int i = 0; i < 3; i++) begin
      ex((i == 2) ? 2'h3 : 2'(i), {1'b0, 5'($urandom)}, 6'($urandom), 32'h40);
      regs();
    end
    $display("test refused done");
    wr(1'b0, 12'h002, 32'h100);
    wr(1'b0, 12'h003, 32'h10c);
    wr(1'b1, 12'h000, 32'h3);
    lb = 32'h100;
    ll = 32'h10c;
    exp_pc.push_back(32'h100);
    exp_pc.push_back(32'h100);
    run = 1'b1;
    for (n = 0; n < 40 && iteration_counter_r !== 32'h0; n++)
      @(negedge clk);
    run = 1'b0;
    if (n == 40) begin
      mismatches++;
      tally_and_finish();
    end
    repeat (3) @(negedge clk);
    chk_val(iteration_counter_r, 32'h0);
    chk_val(32'(exp_pc.size()), 32'h0);
    regs();
    $display("test loop-back done");
    wr(1'b1, 12'h000, 32'h5);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    lb = 32'h0;
    ll = 32'h0;
    regs();
    chk_val(iteration_counter_r, 32'h0);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule // zero_overhead_loop_unit_tb
